// ===== design/sse_cmd_engine.sv
// Purpose: addressed sampling command engine with AHB-Lite register slave
// Assumes: serial framing decoded upstream; each command is one word written to the command register
// Notes: readings leave as raw uncorrected counts; unit arithmetic happens downstream
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.

module sse_cmd_engine #(
  parameter logic [6:0] OWN_ADDR = 7'h01,
  parameter bit DS_SUPPORTED = 1'b1,
  parameter bit PARITY_FIXED = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pres_osc,
  input wire logic temp_osc,
  output logic tx_valid,
  output logic [31:0] tx_data,
  output logic [1:0] tx_kind,
  output logic fwd_dump,
  output logic nvm_store,
  output logic [2:0] baud_code,
  output logic [1:0] parity_code
);
  if (OWN_ADDR == 7'h00 || OWN_ADDR >= sse_pkg::GLOBAL_ADDR) begin : g_bad_addr
    $error("own address must lie in 1..98");
  end

  typedef enum {ST_IDLE, ST_TEMP, ST_PRES} sse_st_e;

  typedef struct packed {
    logic sample;
    logic temp_first;
    logic pres_final;
    logic loop;
    logic hold;
    logic burst;
    sse_pkg::sse_kind_e kind;
  } sse_mode_s;

  typedef struct packed {
    logic rdy;
    logic err;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_off;
    sse_st_e st;
    sse_pkg::sse_op_e op;
    logic start;
    logic abort;
    logic sel_temp;
    logic [23:0] per;
    logic [31:0] tcount;
    logic [31:0] held;
    sse_pkg::sse_kind_e held_kind;
    logic held_valid;
    logic dump_pend;
    logic dump_seq;
    logic tx_valid;
    logic [31:0] tx_data;
    sse_pkg::sse_kind_e tx_kind;
    logic fwd_next;
    logic fwd;
    logic nvm_store;
    logic nvm_arm;
    logic [6:0] own_addr;
    logic [2:0] baud;
    logic lock;
    logic [1:0] parity;
    logic [13:0] pres_res;
    logic [15:0] temp_res;
    logic [3:0] unit;
    logic [15:0] uf;
    logic [1:0] md;
  } sse_ce_s;

  function automatic sse_mode_s mode_of(input sse_pkg::sse_op_e op);
    sse_mode_s m;
    m = '0;
    // fields: sample, temp_first, pres_final, loop, hold, burst
    case (op)
      sse_pkg::OP_SEND_ONE_PRESSURE_PERIOD: m = {6'b101000, sse_pkg::KIND_PRES_PERIOD};
      sse_pkg::OP_STREAM_PRESSURE_PERIODS: m = {6'b101100, sse_pkg::KIND_PRES_PERIOD};
      sse_pkg::OP_SEND_ONE_PRESSURE: m = {6'b111000, sse_pkg::KIND_PRES};
      sse_pkg::OP_STREAM_PRESSURE: m = {6'b111100, sse_pkg::KIND_PRES};
      sse_pkg::OP_HOLD_ONE_PRESSURE: m = {6'b111010, sse_pkg::KIND_PRES};
      sse_pkg::OP_HOLD_ONE_PRESSURE_PERIOD: m = {6'b101010, sse_pkg::KIND_PRES_PERIOD};
      sse_pkg::OP_BURST_PRESSURE: m = {6'b111101, sse_pkg::KIND_PRES};
      sse_pkg::OP_SEND_ONE_TEMP_PERIOD: m = {6'b110000, sse_pkg::KIND_TEMP_PERIOD};
      sse_pkg::OP_STREAM_TEMP_PERIODS: m = {6'b110100, sse_pkg::KIND_TEMP_PERIOD};
      sse_pkg::OP_SEND_ONE_TEMPERATURE: m = {6'b110000, sse_pkg::KIND_TEMP};
      sse_pkg::OP_STREAM_TEMPERATURE: m = {6'b110100, sse_pkg::KIND_TEMP};
      sse_pkg::OP_HOLD_ONE_TEMPERATURE: m = {6'b110010, sse_pkg::KIND_TEMP};
      sse_pkg::OP_HOLD_ONE_TEMP_PERIOD: m = {6'b110010, sse_pkg::KIND_TEMP_PERIOD};
      default: m = '0;
    endcase
    return m;
  endfunction

  sse_ce_s q;
  sse_ce_s d;
  sse_pkg::sse_cmd_s cw;
  sse_pkg::sse_status_s stat;
  sse_mode_s nm;
  sse_mode_s cm;
  logic addr_take;
  logic cmd_take;
  logic is_glob;
  logic addressed;
  logic fin;
  logic acq_hold;
  logic accepted;

  sse_cnt_if cif ();

  sse_osc_counter u_cnt (
    .hclk(hclk),
    .hresetn(hresetn),
    .pres_osc(pres_osc),
    .temp_osc(temp_osc),
    .cif(cif.cnt)
  );

  assign cw = sse_pkg::sse_cmd_s'(hwdata);
  assign cmd_take = q.wr_pend && q.wr_off == sse_pkg::OFF_CMD;
  assign is_glob = cw.dest == sse_pkg::GLOBAL_ADDR;
  assign addressed = cmd_take && (is_glob || cw.dest == q.own_addr);
  assign nm = mode_of(cw.op);
  assign cm = mode_of(q.op);
  assign addr_take = hsel && hready && htrans[1];

  always_comb begin
    stat = '0;
    stat.own_addr = q.own_addr;
    stat.unit = q.unit;
    stat.parity = q.parity;
    stat.baud = q.baud;
    stat.lock = q.lock;
    stat.nvm_arm = q.nvm_arm;
    stat.dump_pend = q.dump_pend;
    stat.held_valid = q.held_valid;
    stat.busy = q.st != ST_IDLE;
  end

  always_comb begin
    d = q;
    fin = 1'b0;
    acq_hold = 1'b0;
    accepted = 1'b0;
    d.start = 1'b0;
    d.abort = 1'b0;
    d.tx_valid = 1'b0;
    d.nvm_store = 1'b0;
    d.fwd = q.fwd_next;
    d.fwd_next = 1'b0;
    // bus address phase; data phase follows with zero wait
    d.wr_pend = addr_take && hwrite;
    d.wr_off = haddr[7:0];
    if (addr_take && !hwrite) begin
      case (haddr[7:0])
        sse_pkg::OFF_STATUS: d.rdata = stat;
        sse_pkg::OFF_RESULT: d.rdata = q.tx_data;
        sse_pkg::OFF_RES_CFG: d.rdata = {q.temp_res, 2'b00, q.pres_res};
        sse_pkg::OFF_MISC: d.rdata = {q.uf, 10'h000, q.md, 2'b00, q.tx_kind};
        default: d.rdata = '0;
      endcase
    end
    // counter completion
    if (cif.done && q.st == ST_TEMP && cm.pres_final) begin
      d.tcount = cif.count;
      d.start = 1'b1;
      d.sel_temp = 1'b0;
      d.st = ST_PRES;
    end else if (cif.done && q.st != ST_IDLE) begin
      fin = 1'b1;
      if (cm.loop) begin
        d.start = 1'b1;
        d.sel_temp = cm.temp_first && !cm.burst;
        d.st = d.sel_temp ? ST_TEMP : ST_PRES;
      end else begin
        d.st = ST_IDLE;
      end
    end
    if (fin && cm.hold) begin
      d.held = cif.count;
      d.held_kind = cm.kind;
      d.held_valid = 1'b1;
    end
    if (fin && (!cm.hold || q.dump_pend)) begin
      d.tx_valid = 1'b1;
      d.tx_data = cif.count;
      d.tx_kind = cm.kind;
      d.fwd_next = cm.hold && q.dump_seq;
      d.dump_pend = 1'b0;
    end
    // new addressed command
    if (addressed) begin
      d.nvm_arm = 1'b0;
      acq_hold = q.st != ST_IDLE && cm.hold && !fin;
      if (nm.sample) begin
        d.abort = 1'b1;
        d.start = 1'b1;
        d.op = cw.op;
        d.sel_temp = nm.temp_first;
        d.st = nm.temp_first ? ST_TEMP : ST_PRES;
        d.held_valid = 1'b0;
        d.dump_pend = 1'b0;
      end else if (cw.op == sse_pkg::OP_DUMP_HELD_READING
                   || (cw.op == sse_pkg::OP_DUMP_IN_LOOP_ORDER && DS_SUPPORTED)) begin
        d.dump_seq = cw.op == sse_pkg::OP_DUMP_IN_LOOP_ORDER;
        if (acq_hold) begin
          d.dump_pend = 1'b1;
        end else begin
          d.abort = 1'b1;
          d.st = ST_IDLE;
          if (d.held_valid) begin
            d.tx_valid = 1'b1;
            d.tx_data = d.held;
            d.tx_kind = d.held_kind;
            d.fwd_next = d.dump_seq;
          end
        end
      end else begin
        d.abort = 1'b1;
        d.st = ST_IDLE;
        d.held_valid = 1'b0;
        d.dump_pend = 1'b0;
        case (cw.op)
          sse_pkg::OP_BAUD_RATE_SET: begin
            if (is_glob && !q.lock) begin
              d.baud = cw.param[2:0];
            end
          end
          sse_pkg::OP_RATE_LOCK: begin
            if (is_glob) begin
              d.lock = cw.param[0];
            end
          end
          sse_pkg::OP_LOOP_AUTO_NUMBER: begin
            if (is_glob && cw.param[6:0] < sse_pkg::GLOBAL_ADDR - 7'h01) begin
              d.own_addr = cw.param[6:0] + 7'h01;
              accepted = 1'b1;
            end
          end
          sse_pkg::OP_PARITY_SELECT: begin
            if (is_glob && !q.lock && !PARITY_FIXED && cw.param[1:0] <= sse_pkg::PARITY_MAX) begin
              d.parity = cw.param[1:0];
            end
          end
          sse_pkg::OP_NVM_WRITE_ARM: d.nvm_arm = 1'b1;
          sse_pkg::OP_PRESSURE_RESOLUTION: begin
            if (!is_glob && cw.param != 16'h0000 && cw.param <= 16'(sse_pkg::PRES_RES_MAX)) begin
              d.pres_res = cw.param[13:0];
              d.temp_res = {cw.param[13:0], 2'b00};
              accepted = 1'b1;
            end
          end
          sse_pkg::OP_TEMPERATURE_RESOLUTION: begin
            if (!is_glob && cw.param != 16'h0000) begin
              d.temp_res = cw.param;
              accepted = 1'b1;
            end
          end
          sse_pkg::OP_UNIT_SELECT: begin
            if (!is_glob && cw.param <= 16'(sse_pkg::UNIT_MAX)) begin
              d.unit = cw.param[3:0];
              accepted = 1'b1;
            end
          end
          sse_pkg::OP_USER_UNIT_FACTOR: begin
            if (!is_glob) begin
              d.uf = cw.param;
              accepted = 1'b1;
            end
          end
          sse_pkg::OP_POWERUP_BACKGROUND_MODE: begin
            if (!is_glob) begin
              d.md = cw.param[1:0];
              accepted = 1'b1;
            end
          end
          default: d.abort = 1'b1;
        endcase
        d.nvm_store = q.nvm_arm && accepted;
      end
    end
    d.per = d.sel_temp ? 24'(d.temp_res) * sse_pkg::INTEG_MULT
                       : 24'(d.pres_res) * sse_pkg::INTEG_MULT;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.rdy <= 1'b1;
      q.own_addr <= OWN_ADDR;
      q.baud <= sse_pkg::BAUD_DEF;
      q.parity <= sse_pkg::PARITY_NONE;
      q.pres_res <= sse_pkg::PRES_RES_DEF;
      q.temp_res <= sse_pkg::TEMP_RES_DEF;
      q.unit <= sse_pkg::UNIT_DEF;
      q.uf <= sse_pkg::UF_DEF;
    end else begin
      q <= d;
    end
  end

  assign cif.start = q.start;
  assign cif.abort = q.abort;
  assign cif.sel_temp = q.sel_temp;
  assign cif.periods = q.per;
  assign hrdata = q.rdata;
  assign hreadyout = q.rdy;
  assign hresp = q.err;
  assign tx_valid = q.tx_valid;
  assign tx_data = q.tx_data;
  assign tx_kind = q.tx_kind;
  assign fwd_dump = q.fwd;
  assign nvm_store = q.nvm_store;
  assign baud_code = q.baud;
  assign parity_code = q.parity;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  ds_forward_a: assert property (q.fwd |-> $past(q.tx_valid))
    else $error("forwarded dump without a preceding reading");
  early_no_ds_a: assert property (!DS_SUPPORTED |-> !q.fwd)
    else $error("loop-order dump acted on in early firmware");
  lock_baud_a: assert property ((q.baud != $past(q.baud)) |-> !$past(q.lock))
    else $error("rate changed while locked");
  parity_fixed_a: assert property (PARITY_FIXED |-> q.parity == sse_pkg::PARITY_NONE)
    else $error("parity left fixed framing");
  unit_range_a: assert property (q.unit <= sse_pkg::UNIT_MAX)
    else $error("unit code beyond 8");
  arm_once_a: assert property (addressed && cw.op != sse_pkg::OP_NVM_WRITE_ARM |=> !q.nvm_arm)
    else $error("write arm outlived next command");
  foreign_drop_a: assert property (cmd_take && !addressed && q.st == ST_IDLE |=> !q.start)
    else $error("command for another unit started a count");
  cancel_run_a: assert property (addressed && nm.sample |=> q.abort && q.start)
    else $error("new sampling command did not restart the counter");
  dump_sends_a: assert property (addressed && cw.op == sse_pkg::OP_DUMP_HELD_READING
      && q.held_valid && q.st == ST_IDLE |=> q.tx_valid && q.tx_data == $past(q.held))
    else $error("dump did not send the held value");
  stream_restart_a: assert property (cif.done && q.st == ST_PRES && cm.loop && !addressed
      |=> q.start ##1 cif.start == 1'b0)
    else $error("streamed pressure not restarted");
  comp_order_a: assert property (cif.done && q.st == ST_TEMP && cm.pres_final && !addressed
      |=> q.start && !q.sel_temp && q.st == ST_PRES)
    else $error("pressure count did not follow temperature");
  hold_quiet_a: assert property (cif.done && q.st != ST_IDLE && cm.hold && !cm.pres_final
      && !q.dump_pend && !addressed |=> !q.tx_valid)
    else $error("hold sent a reading without dump");
  global_setup_a: assert property (addressed && is_glob
      && cw.op == sse_pkg::OP_PRESSURE_RESOLUTION |=> $stable(q.pres_res))
    else $error("global resolution command took effect");
  global_only_a: assert property (addressed && !is_glob
      && cw.op == sse_pkg::OP_BAUD_RATE_SET |=> $stable(q.baud))
    else $error("individual rate command took effect");
endmodule

// ===== design/sse_osc_counter.sv
// Purpose: counts hclk cycles over a number of sensor oscillator periods
// Assumes: oscillator pins asynchronous to hclk
// Notes: periods must be at least one
module sse_osc_counter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pres_osc,
  input wire logic temp_osc,
  sse_cnt_if.cnt cif
);
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] hist;
    logic busy;
    logic armed;
    logic sel_temp;
    logic [23:0] left;
    logic [31:0] cnt;
    logic done;
  } sse_oc_s;

  sse_oc_s q;
  sse_oc_s d;
  logic rise;

  always_comb begin
    d = q;
    d.sync1 = {temp_osc, pres_osc};
    d.sync2 = q.sync1;
    d.hist = q.sync2;
    d.done = 1'b0;
    rise = q.sel_temp ? (q.sync2[1] & ~q.hist[1]) : (q.sync2[0] & ~q.hist[0]);
    if (cif.abort || cif.start) begin
      d.busy = cif.start;
      d.armed = 1'b0;
      d.sel_temp = cif.sel_temp;
      d.left = cif.periods;
      d.cnt = '0;
    end else if (q.busy) begin
      // first edge opens the gate, then each cycle counts
      if (q.armed) begin
        d.cnt = q.cnt + 32'h1;
      end
      if (rise && !q.armed) begin
        d.armed = 1'b1;
      end else if (rise && q.left == 24'h1) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else if (rise) begin
        d.left = q.left - 24'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cif.done = q.done;
  assign cif.count = q.cnt;
endmodule

// ===== shared/sse_cnt_if.sv
// Purpose: link between sequencer and oscillator counter
// Assumes: one clock, hclk
// Notes: start and abort are one-cycle pulses
interface sse_cnt_if;
  logic start;
  logic abort;
  logic sel_temp;
  logic [23:0] periods;
  logic done;
  logic [31:0] count;
  modport seq (output start, abort, sel_temp, periods, input done, count);
  modport cnt (input start, abort, sel_temp, periods, output done, count);
endinterface

// ===== shared/sse_pkg.sv
// Purpose: shared constants and types of the sampling command engine
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: opcode codes follow the enum order
package sse_pkg;
  localparam logic [6:0] GLOBAL_ADDR = 7'h63;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;
  localparam logic [7:0] OFF_RES_CFG = 8'h0C;
  localparam logic [7:0] OFF_MISC = 8'h10;
  localparam logic [23:0] INTEG_MULT = 24'h000064;
  localparam logic [13:0] PRES_RES_DEF = 14'h00EE;
  localparam logic [15:0] TEMP_RES_DEF = 16'h03B8;
  localparam logic [13:0] PRES_RES_MAX = 14'h3FFF;
  localparam logic [2:0] BAUD_DEF = 3'h6;
  localparam logic [3:0] UNIT_MAX = 4'h8;
  localparam logic [3:0] UNIT_DEF = 4'h1;
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_MAX = 2'h2;
  localparam logic [15:0] UF_DEF = 16'h0001;

  typedef enum logic [4:0] {
    OP_SEND_ONE_PRESSURE_PERIOD,
    OP_STREAM_PRESSURE_PERIODS,
    OP_SEND_ONE_PRESSURE,
    OP_STREAM_PRESSURE,
    OP_HOLD_ONE_PRESSURE,
    OP_HOLD_ONE_PRESSURE_PERIOD,
    OP_BURST_PRESSURE,
    OP_SEND_ONE_TEMP_PERIOD,
    OP_STREAM_TEMP_PERIODS,
    OP_SEND_ONE_TEMPERATURE,
    OP_STREAM_TEMPERATURE,
    OP_HOLD_ONE_TEMPERATURE,
    OP_HOLD_ONE_TEMP_PERIOD,
    OP_DUMP_HELD_READING,
    OP_DUMP_IN_LOOP_ORDER,
    OP_BAUD_RATE_SET,
    OP_RATE_LOCK,
    OP_LOOP_AUTO_NUMBER,
    OP_PARITY_SELECT,
    OP_NVM_WRITE_ARM,
    OP_PRESSURE_RESOLUTION,
    OP_TEMPERATURE_RESOLUTION,
    OP_UNIT_SELECT,
    OP_USER_UNIT_FACTOR,
    OP_POWERUP_BACKGROUND_MODE
  } sse_op_e;

  typedef enum logic [1:0] {
    KIND_PRES_PERIOD,
    KIND_PRES,
    KIND_TEMP_PERIOD,
    KIND_TEMP
  } sse_kind_e;

  typedef struct packed {
    logic [15:0] param;
    logic [2:0] rsv1;
    sse_op_e op;
    logic rsv0;
    logic [6:0] dest;
  } sse_cmd_s;

  typedef struct packed {
    logic [10:0] rsv;
    logic [6:0] own_addr;
    logic [3:0] unit;
    logic [1:0] parity;
    logic [2:0] baud;
    logic lock;
    logic nvm_arm;
    logic dump_pend;
    logic held_valid;
    logic busy;
  } sse_status_s;
endpackage

// ===== test/sse_cmd_engine_test.sv
// Purpose: self-checking bench of the sampling command engine
// Assumes: zero-wait AHB-Lite slave; oscillator model on both pins
// Notes: resolutions cut to one, so a count spans 100 periods
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sse_cmd_engine_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] PCNT = 32'h000003E8; // 100 periods of 10 clocks
  localparam logic [31:0] TCNT = 32'h000004B0; // 100 periods of 12 clocks
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] kind;
    logic fwd;
  } sse_exp_s;
  sse_exp_s exp_q[$];
  sse_exp_s e;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int nvm_cnt = 0;
  logic fwd_exp = 1'b0;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, pres_osc, temp_osc, tx_valid, fwd_dump, nvm_store;
  logic [1:0] htrans, tx_kind, parity_code;
  logic [2:0] baud_code, hsize;
  logic [3:0] u;
  logic [31:0] haddr, hwdata, hrdata, tx_data, rd, lfsr;
  logic [4:0] sop[9] = '{5'h00, 5'h02, 5'h07, 5'h09, 5'h01, 5'h03, 5'h08, 5'h0A, 5'h06};
  logic [1:0] skind[9] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
  logic [31:0] sdat[9] = '{PCNT, PCNT, TCNT, TCNT, PCNT, PCNT, TCNT, TCNT, PCNT};
  always #2 hclk = ~hclk;
  sse_cmd_engine #(.OWN_ADDR(7'h01), .DS_SUPPORTED(1'b1), .PARITY_FIXED(1'b1)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pres_osc(pres_osc), .temp_osc(temp_osc), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_kind(tx_kind), .fwd_dump(fwd_dump), .nvm_store(nvm_store), .baud_code(baud_code),
    .parity_code(parity_code)
  );
  sse_osc_model osc (.pres_osc(pres_osc), .temp_osc(temp_osc));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] cmd(input logic [6:0] d, input logic [4:0] op, input logic [15:0] p);
    return {p, 3'h0, op, 1'b0, d};
  endfunction
  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // single word transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  task automatic send(input logic [6:0] d, input logic [4:0] op, input logic [15:0] p);
    bus(1'b1, sse_pkg::OFF_CMD, cmd(d, op, p));
    repeat (3) @(posedge hclk);
  endtask
  task automatic push(input logic [31:0] d, input logic [1:0] k, input logic f);
    exp_q.push_back({d, k, f});
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 9000) begin
      @(posedge hclk);
      n++;
    end
    repeat (2) @(posedge hclk);
    `CHK(exp_q.size(), 0)
  endtask
  // monitor: every send must match the oldest note
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      complete_run();
    end else if (hresetn === 1'b1) begin
      if (nvm_store === 1'b1) nvm_cnt++;
      `CHK(fwd_dump, fwd_exp)
      fwd_exp = 1'b0;
      if (tx_valid === 1'b1) begin
        if (exp_q.size() == 0) `CHK(tx_valid, 1'b0)
        else begin
          e = exp_q.pop_front();
          `CHK(tx_data, e.data)
          `CHK(tx_kind, e.kind)
          fwd_exp = e.fwd;
        end
      end
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h00000000;
    lfsr = 32'h00010C46;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, sse_pkg::OFF_STATUS, 32'h00000000);
    `CHK(rd, 32'h000044C0)
    bus(1'b0, 8'h20, 32'h00000000);
    `CHK(rd, 32'h00000000)
    lfsr = nxt(lfsr);
    send(7'h63, sse_pkg::OP_PRESSURE_RESOLUTION, {2'h0, lfsr[13:1], 1'b1});
    bus(1'b0, sse_pkg::OFF_RES_CFG, 32'h00000000);
    `CHK(rd, 32'h03B800EE)
    send(7'h01, sse_pkg::OP_PRESSURE_RESOLUTION, 16'h0001);
    bus(1'b0, sse_pkg::OFF_RES_CFG, 32'h00000000);
    `CHK(rd, 32'h00040001)
    send(7'h01, sse_pkg::OP_TEMPERATURE_RESOLUTION, 16'h0001);
    send(7'h01, sse_pkg::OP_BAUD_RATE_SET, 16'h0003);
    `CHK(baud_code, sse_pkg::BAUD_DEF)
    send(7'h63, sse_pkg::OP_BAUD_RATE_SET, 16'h0003);
    `CHK(baud_code, 3'h3)
    send(7'h63, sse_pkg::OP_PARITY_SELECT, 16'h0001);
    `CHK(parity_code, sse_pkg::PARITY_NONE)
    send(7'h63, sse_pkg::OP_RATE_LOCK, 16'h0001);
    send(7'h63, sse_pkg::OP_BAUD_RATE_SET, 16'h0005);
    `CHK(baud_code, 3'h3)
    lfsr = nxt(lfsr);
    u = 4'(lfsr % 32'h00000009);
    send(7'h63, sse_pkg::OP_NVM_WRITE_ARM, 16'h0000);
    send(7'h01, sse_pkg::OP_UNIT_SELECT, {12'h000, u});
    send(7'h01, sse_pkg::OP_UNIT_SELECT, 16'h0009);
    send(7'h01, sse_pkg::OP_UNIT_SELECT, {12'h000, u});
    bus(1'b0, sse_pkg::OFF_STATUS, 32'h00000000);
    `CHK(rd[13:10], u)
    `CHK(nvm_cnt, 1)
    // singles, then streams stopped by an absorbed opcode
    for (int i = 0; i < 9; i++) begin
      push(sdat[i], skind[i], 1'b0);
      if (i > 3) push(sdat[i], skind[i], 1'b0);
      send(i[0] ? 7'h63 : 7'h01, sop[i], 16'h0000);
      drain();
      if (i > 3) send(7'h01, 5'h1F, 16'h0000);
      repeat (3000) @(posedge hclk);
    end
    send(7'h02, sse_pkg::OP_SEND_ONE_PRESSURE_PERIOD, 16'h0000);
    repeat (3000) @(posedge hclk);
    send(7'h01, sse_pkg::OP_HOLD_ONE_PRESSURE, 16'h0000);
    repeat (3000) @(posedge hclk);
    push(PCNT, 2'h1, 1'b0);
    send(7'h01, sse_pkg::OP_DUMP_HELD_READING, 16'h0000);
    drain();
    push(TCNT, 2'h2, 1'b0);
    send(7'h63, sse_pkg::OP_HOLD_ONE_TEMP_PERIOD, 16'h0000);
    send(7'h01, sse_pkg::OP_DUMP_HELD_READING, 16'h0000);
    drain();
    send(7'h01, sse_pkg::OP_HOLD_ONE_PRESSURE_PERIOD, 16'h0000);
    repeat (3000) @(posedge hclk);
    push(PCNT, 2'h0, 1'b1);
    send(7'h63, sse_pkg::OP_DUMP_IN_LOOP_ORDER, 16'h0000);
    drain();
    send(7'h01, sse_pkg::OP_HOLD_ONE_TEMPERATURE, 16'h0000);
    repeat (3000) @(posedge hclk);
    send(7'h01, sse_pkg::OP_TEMPERATURE_RESOLUTION, 16'h0001);
    send(7'h01, sse_pkg::OP_DUMP_HELD_READING, 16'h0000);
    repeat (3000) @(posedge hclk);
    // last send was the loop-order dump of a pressure period
    bus(1'b0, sse_pkg::OFF_RESULT, 32'h00000000);
    `CHK(rd, PCNT)
    bus(1'b0, sse_pkg::OFF_MISC, 32'h00000000);
    `CHK(rd, 32'h00010000)
    complete_run();
  end
endmodule

// ===== test/sse_osc_model.sv
// Purpose: free-running pressure and temperature resonator pins
// Assumes: resonators run whether or not a count is in progress
// Notes: periods are whole bench-clock multiples, edges off the clock edge
module sse_osc_model #(
  parameter int P_NS = 40,
  parameter int T_NS = 48
) (
  output logic pres_osc,
  output logic temp_osc
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    pres_osc = 1'b0;
    temp_osc = 1'b0;
    #1;
    fork
      forever #(P_NS / 2) pres_osc = ~pres_osc;
      forever #(T_NS / 2) temp_osc = ~temp_osc;
    join
  end
endmodule
